/* verilog/pef_flags.sv */
// Peripheral event flag register with mask and interrupt output
`timescale 1ns/100ps
`include "pef_defs.svh"
module pef_flags
  import pef_pkg::*;
(
  input  wire logic                   i_mclk,
  input  wire logic                   i_rst_b,
  input  wire pef_events_s            i_events,
  input  wire pef_ccm_e               i_ccm_mode,
  input  wire logic [`PEF_ADDR_W-1:0] i_addr,
  input  wire logic [7:0]             i_wdata,
  input  wire logic                   i_wr,
  input  wire logic                   i_rd,
  output logic [7:0]                  o_rdata,
  output logic [7:0]                  o_flags,
  output logic                        o_irq
);

  // ************************************************************
  // Event gathering
  // ************************************************************
  pef_state_s st_q;
  pef_state_s st_d;
  logic [7:0] set_v;

  function automatic logic [7:0] pef_impl(input logic [7:0] v);
    pef_impl = v & `PEF_IMPL_MASK;
  endfunction

  always_comb
  begin
    set_v = 8'h00;
    set_v[`PEF_BIT_CONV] = i_events.conv_done;
    set_v[`PEF_BIT_SERIAL] = i_events.serial_xfer;
    // mode selects the source; pulse-width mode sets nothing
    case (i_ccm_mode)
      PEF_CCM_CAPTURE: set_v[`PEF_BIT_CAPCMP] = i_events.capture;
      PEF_CCM_COMPARE: set_v[`PEF_BIT_CAPCMP] = i_events.compare;
      PEF_CCM_PWM:     set_v[`PEF_BIT_CAPCMP] = 1'b0;
      default:         set_v[`PEF_BIT_CAPCMP] = 1'b0;
    endcase
    set_v[`PEF_BIT_PERIOD] = i_events.period_match;
    set_v[`PEF_BIT_OVF] = i_events.wide_ovf;
  end

  // ************************************************************
  // Address decode
  // ************************************************************
  logic       wr_flags;
  logic       wr_mask;
  logic       rd_flags;
  logic       rd_mask;
  logic [7:0] clr_v;

  // One decode shared by the register file and the checks
  function automatic logic pef_hit(input logic                   strobe,
                                   input logic [`PEF_ADDR_W-1:0] a,
                                   input logic [`PEF_ADDR_W-1:0] ofs);
    pef_hit = strobe && (a == ofs);
  endfunction

  always_comb
  begin
    wr_flags = pef_hit(i_wr, i_addr, `PEF_OFS_FLAGS);
    wr_mask  = pef_hit(i_wr, i_addr, `PEF_OFS_MASK);
    rd_flags = pef_hit(i_rd, i_addr, `PEF_OFS_FLAGS);
    rd_mask  = pef_hit(i_rd, i_addr, `PEF_OFS_MASK);
    // only implemented bits can be cleared
    clr_v    = wr_flags ? pef_impl(i_wdata) : 8'h00;
  end

  // ************************************************************
  // Register file
  // ************************************************************
  // Flags are write-one-to-clear, so clearing one flag never wipes
  // another event that arrived since software last read the register
  always_comb
  begin
    st_d       = st_q;
    st_d.rdata = 8'h00;
    // software clears a flag by writing a one to it
    st_d.flags = st_q.flags & ~clr_v;
    if (wr_mask)
    begin
      st_d.mask = pef_impl(i_wdata);
    end
    // set wins over a clear in the same cycle
    st_d.flags = st_d.flags | pef_impl(set_v);
    // Idle and unmapped reads return zero so a stale word never lingers
    if (rd_flags)
    begin
      st_d.rdata = pef_impl(st_q.flags);
    end
    else if (rd_mask)
    begin
      st_d.rdata = pef_impl(st_q.mask);
    end
  end

  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_b)
    begin
      st_q.flags <= `PEF_RESET_FLAGS;
      st_q.mask  <= `PEF_RESET_MASK;
      st_q.rdata <= 8'h00;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign o_rdata = st_q.rdata;
  assign o_flags = st_q.flags;
  // Level interrupt; software should clear stale flags before unmasking
  assign o_irq   = |(st_q.flags & st_q.mask);

  // ************************************************************
  // Checks
  // ************************************************************
  // a conversion event lands in its flag
  event_sets_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    i_events.conv_done |=> o_flags[`PEF_BIT_CONV])
    else $error("conversion event lost");
  conv_hold_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (o_flags[`PEF_BIT_CONV] && !(i_wr && i_addr == `PEF_OFS_FLAGS))
      |=> o_flags[`PEF_BIT_CONV])
    else $error("conversion flag dropped");
  serial_set_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    i_events.serial_xfer |=> o_flags[`PEF_BIT_SERIAL])
    else $error("serial flag not set");
  capture_set_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (i_ccm_mode == PEF_CCM_CAPTURE && i_events.capture)
      |=> o_flags[`PEF_BIT_CAPCMP])
    else $error("capture flag not set");
  compare_set_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (i_ccm_mode == PEF_CCM_COMPARE && i_events.compare)
      |=> o_flags[`PEF_BIT_CAPCMP])
    else $error("compare flag not set");
  pwm_quiet_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (i_ccm_mode == PEF_CCM_PWM && !o_flags[`PEF_BIT_CAPCMP]
      && !(i_wr && i_addr == `PEF_OFS_FLAGS)) |=> !o_flags[`PEF_BIT_CAPCMP])
    else $error("flag set in pulse-width mode");
  period_set_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    i_events.period_match |=> o_flags[`PEF_BIT_PERIOD])
    else $error("period flag not set");
  ovf_hold_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    $fell(o_flags[`PEF_BIT_OVF]) |-> $past(i_wr) && $past(i_addr) == `PEF_OFS_FLAGS)
    else $error("overflow cleared without write");
  unimpl_zero_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    $past(i_rd) |-> (o_rdata & ~`PEF_IMPL_MASK) == 8'h00 && o_flags[7] == 1'b0)
    else $error("unimplemented bit nonzero");
  set_wins_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (i_wr && i_addr == `PEF_OFS_FLAGS && i_events.wide_ovf) |=> o_flags[`PEF_BIT_OVF])
    else $error("set lost to clear");
  // Interrupt rises only after an event or an unmask
  irq_level_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    $rose(o_irq) |-> $past(|set_v) || $past(wr_mask))
    else $error("interrupt rose without cause");

  // ************************************************************
  // Checks per flag
  // ************************************************************
  // a flag rises only from its own event
  flag_source_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    $past(i_rst_b) |-> (o_flags & ~$past(o_flags) & ~$past(set_v)) == 8'h00)
    else $error("flag rose without event");

  // conversion flag cleared by a one
  conv_clear_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (wr_flags && i_wdata[`PEF_BIT_CONV] && !i_events.conv_done)
      |=> !o_flags[`PEF_BIT_CONV])
    else $error("conversion flag not cleared");

  conv_quiet_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (!o_flags[`PEF_BIT_CONV] && !i_events.conv_done)
      |=> !o_flags[`PEF_BIT_CONV])
    else $error("conversion flag set without event");

  serial_hold_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (o_flags[`PEF_BIT_SERIAL] && !(wr_flags && i_wdata[`PEF_BIT_SERIAL]))
      |=> o_flags[`PEF_BIT_SERIAL])
    else $error("serial flag dropped");

  // serial flag cleared by a one
  serial_clear_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (wr_flags && i_wdata[`PEF_BIT_SERIAL] && !i_events.serial_xfer)
      |=> !o_flags[`PEF_BIT_SERIAL])
    else $error("serial flag not cleared");

  serial_quiet_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (!o_flags[`PEF_BIT_SERIAL] && !i_events.serial_xfer)
      |=> !o_flags[`PEF_BIT_SERIAL])
    else $error("serial flag set without event");

  capcmp_hold_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (o_flags[`PEF_BIT_CAPCMP] && !(wr_flags && i_wdata[`PEF_BIT_CAPCMP]))
      |=> o_flags[`PEF_BIT_CAPCMP])
    else $error("capture flag dropped");

  // compare event ignored in capture mode
  capture_only_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (i_ccm_mode == PEF_CCM_CAPTURE && !i_events.capture && !o_flags[`PEF_BIT_CAPCMP])
      |=> !o_flags[`PEF_BIT_CAPCMP])
    else $error("capture flag set by other event");

  // capture event ignored in compare mode
  compare_only_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (i_ccm_mode == PEF_CCM_COMPARE && !i_events.compare && !o_flags[`PEF_BIT_CAPCMP])
      |=> !o_flags[`PEF_BIT_CAPCMP])
    else $error("compare flag set by other event");

  // compare flag cleared by a one
  capcmp_clear_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (wr_flags && i_wdata[`PEF_BIT_CAPCMP] && !set_v[`PEF_BIT_CAPCMP])
      |=> !o_flags[`PEF_BIT_CAPCMP])
    else $error("compare flag not cleared");

  period_hold_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (o_flags[`PEF_BIT_PERIOD] && !(wr_flags && i_wdata[`PEF_BIT_PERIOD]))
      |=> o_flags[`PEF_BIT_PERIOD])
    else $error("period flag dropped");

  // period flag cleared by a one
  period_clear_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (wr_flags && i_wdata[`PEF_BIT_PERIOD] && !i_events.period_match)
      |=> !o_flags[`PEF_BIT_PERIOD])
    else $error("period flag not cleared");

  ovf_set_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    i_events.wide_ovf |=> o_flags[`PEF_BIT_OVF])
    else $error("overflow flag not set");

  // writing a zero keeps the overflow flag
  ovf_keep_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (o_flags[`PEF_BIT_OVF] && !(wr_flags && i_wdata[`PEF_BIT_OVF]))
      |=> o_flags[`PEF_BIT_OVF])
    else $error("overflow flag dropped");

  // overflow flag cleared by a one
  ovf_clear_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (wr_flags && i_wdata[`PEF_BIT_OVF] && !i_events.wide_ovf)
      |=> !o_flags[`PEF_BIT_OVF])
    else $error("overflow flag not cleared");

  serial_wins_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (wr_flags && i_events.serial_xfer) |=> o_flags[`PEF_BIT_SERIAL])
    else $error("serial set lost to clear");

  period_wins_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (wr_flags && i_events.period_match) |=> o_flags[`PEF_BIT_PERIOD])
    else $error("period set lost to clear");

  conv_wins_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (wr_flags && i_events.conv_done) |=> o_flags[`PEF_BIT_CONV])
    else $error("conversion set lost to clear");

  // ************************************************************
  // Checks on the register bus
  // ************************************************************
  // unimplemented flag bits stay zero
  flags_unimpl_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (o_flags & ~`PEF_IMPL_MASK) == 8'h00)
    else $error("unimplemented flag bit set");

  mask_unimpl_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (st_q.mask & ~`PEF_IMPL_MASK) == 8'h00)
    else $error("unimplemented mask bit set");

  // Mask takes the implemented bits of the written word
  mask_write_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    wr_mask |=> st_q.mask == ($past(i_wdata) & `PEF_IMPL_MASK))
    else $error("mask write lost");

  // Mask holds without a write
  mask_hold_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    !wr_mask |=> $stable(st_q.mask))
    else $error("mask changed without write");

  // Flag read returns the flags
  read_flags_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    rd_flags |=> o_rdata == $past(o_flags))
    else $error("flag read wrong");

  // Mask read returns the mask
  read_mask_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    rd_mask |=> o_rdata == $past(st_q.mask))
    else $error("mask read wrong");

  // Read data only in the cycle after a read
  read_idle_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    !i_rd |=> o_rdata == 8'h00)
    else $error("read data without read");

  read_unmapped_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (i_rd && !rd_flags && !rd_mask) |=> o_rdata == 8'h00)
    else $error("unmapped read nonzero");

  reset_clear_a: assert property (@(posedge i_mclk)
    !i_rst_b |=> (o_flags == 8'h00 && st_q.mask == 8'h00 && o_rdata == 8'h00))
    else $error("reset left state");

  // Interrupt falls only after a write
  irq_fall_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    $fell(o_irq) |-> $past(wr_flags) || $past(wr_mask))
    else $error("interrupt fell without write");

endmodule // pef_flags

/* verilog/pef_defs.svh */
// Constants for the peripheral event flag register block
// How it works
// - Each event sets its flag whatever any enable says.
// - Bit 6 goes to one when a conversion completes and stays until cleared.
// - Bit 3 is set after a serial transfer and software clears it before leaving service.
// - In capture mode bit 2 is set on a timer capture and stays until cleared.
// - In compare mode bit 2 is set on a compare match and stays until cleared.
// - In pulse-width mode bit 2 is never set by the unit.
// - Bit 1 is set when the period timer meets its limit and stays until cleared.
// - Bit 0 is set on wide timer overflow and only reset or a software write clears it.
// - Bits 7, 5 and 4 read as zero and ignore writes.
`ifndef PEF_DEFS_SVH
`define PEF_DEFS_SVH
`define PEF_ADDR_W          8
`define PEF_OFS_FLAGS       8'h0C
`define PEF_OFS_MASK        8'h0D
`define PEF_BIT_CONV        6
`define PEF_BIT_SERIAL      3
`define PEF_BIT_CAPCMP      2
`define PEF_BIT_PERIOD      1
`define PEF_BIT_OVF         0
`define PEF_IMPL_MASK       8'h4F
`define PEF_RESET_FLAGS     8'h00
`define PEF_RESET_MASK      8'h00
`endif

/* verilog/pef_pkg.sv */
// Types for the peripheral event flag register block
package pef_pkg;
  // Capture/compare unit mode as seen by the flag logic
  typedef enum logic [2:0]
  {
    PEF_CCM_CAPTURE = 3'b001,
    PEF_CCM_COMPARE = 3'b010,
    PEF_CCM_PWM     = 3'b100
  } pef_ccm_e;

  typedef struct packed
  {
    logic conv_done;
    logic serial_xfer;
    logic capture;
    logic compare;
    logic period_match;
    logic wide_ovf;
  } pef_events_s;

  typedef struct packed
  {
    logic [7:0] flags;
    logic [7:0] mask;
    logic [7:0] rdata;
  } pef_state_s;
endpackage

/* bench/pef_evt_model.sv */
// Peripheral event source that stands beside the flag block
`timescale 1ns/100ps
module pef_evt_model
  import pef_pkg::*;
(
  input  wire logic       i_mclk,
  input  wire logic       i_go,
  input  wire logic [2:0] i_sel,
  output pef_events_s     o_events
);
  always_ff @(posedge i_mclk)
  begin
    o_events <= i_go ? pef_events_s'(6'h01 << i_sel) : '0;
  end
endmodule // pef_evt_model

/* bench/pef_flags_tb.sv */
// Self-checking bench for the peripheral event flag block
`timescale 1ns/100ps
`include "pef_defs.svh"
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin num_errors++; \
  $display("FAIL %s exp %h got %h", n, e, s); end end
module peripheral_event_flag_register_tb
  import pef_pkg::*;
;
  logic        i_mclk = 0, i_rst_b = 0, i_wr = 0, i_rd = 0, go = 0, o_irq;
  logic [7:0]  i_addr = 8'h00, i_wdata = 8'h00, o_rdata, o_flags, rd_val;
  logic [2:0]  sel = 3'h0;
  pef_ccm_e    i_ccm_mode = PEF_CCM_COMPARE;
  pef_events_s ev_w;
  int          num_errors = 0, checks = 0, cyc = 0;
  logic [7:0]  exp_tab [6] = '{8'h01, 8'h02, 8'h04, 8'h04, 8'h08, 8'h40};

  pef_flags dut (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_events(ev_w),
    .i_ccm_mode(i_ccm_mode), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .o_flags(o_flags), .o_irq(o_irq));
  pef_evt_model peer (.i_mclk(i_mclk), .i_go(go), .i_sel(sel), .o_events(ev_w));

  task complete_run();
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_mclk);
    i_wr <= 1'b0;
    #1;
  endtask
  task rd(input logic [7:0] a);
    @(posedge i_mclk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    #1 rd_val = o_rdata;
  endtask
  task ev(input logic [2:0] s);
    @(posedge i_mclk);
    go <= 1'b1;
    sel <= s;
    @(posedge i_mclk);
    go <= 1'b0;
    @(posedge i_mclk);
    #1;
  endtask

  initial
  begin
    forever #25 i_mclk = ~i_mclk;
  end
  // Hang guard, the run needs fewer than a hundred cycles
  always @(posedge i_mclk)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      num_errors++;
      complete_run();
    end
  end

  initial
  begin
    repeat (3) @(posedge i_mclk);
    i_rst_b <= 1'b1;
    rd(`PEF_OFS_FLAGS);
    `CHK("flags", 8'h00, rd_val)
    rd(`PEF_OFS_MASK);
    `CHK("mask", 8'h00, rd_val)
    `CHK("irq", 1'b0, o_irq)
    $display("test reset done");
    for (int s = 0; s < 6; s++)
    begin
      i_ccm_mode <= (s == 3) ? PEF_CCM_CAPTURE : PEF_CCM_COMPARE;
      ev(3'(s));
      `CHK("flag set", exp_tab[s], o_flags)
      wr(`PEF_OFS_FLAGS, 8'hFF);
      `CHK("flag clr", 8'h00, o_flags)
    end
    i_ccm_mode <= PEF_CCM_PWM;
    ev(3'h2);
    ev(3'h3);
    `CHK("pwm", 8'h00, o_flags)
    $display("test events done");
    i_ccm_mode <= PEF_CCM_CAPTURE;
    for (int s = 0; s < 6; s++)
    begin
      if (s != 2)
        ev(3'(s));
    end
    wr(`PEF_OFS_FLAGS, 8'hB0);
    rd(`PEF_OFS_FLAGS);
    `CHK("unimpl", 8'h4F, rd_val)
    wr(`PEF_OFS_MASK, 8'hFF);
    wr(8'h20, 8'h00);
    rd(`PEF_OFS_MASK);
    `CHK("mask unimpl", 8'h4F, rd_val)
    rd(8'h20);
    `CHK("unmapped", 8'h00, rd_val)
    wr(`PEF_OFS_FLAGS, 8'h40);
    `CHK("clr one", 8'h0F, o_flags)
    wr(`PEF_OFS_MASK, 8'h00);
    wr(`PEF_OFS_FLAGS, 8'hFF);
    `CHK("clr all", 8'h00, o_flags)
    @(posedge i_mclk);
    go <= 1'b1;
    sel <= 3'h0;
    @(posedge i_mclk);
    go <= 1'b0;
    i_wr <= 1'b1;
    i_addr <= `PEF_OFS_FLAGS;
    i_wdata <= 8'h01;
    @(posedge i_mclk);
    i_wr <= 1'b0;
    #1 `CHK("set wins", 8'h01, o_flags)
    $display("test write done");
    wr(`PEF_OFS_FLAGS, 8'hFF);
    wr(`PEF_OFS_MASK, 8'hFF);
    `CHK("irq idle", 1'b0, o_irq)
    ev(3'h0);
    `CHK("irq on", 1'b1, o_irq)
    wr(`PEF_OFS_MASK, 8'h00);
    `CHK("irq mask", 1'b0, o_irq)
    wr(`PEF_OFS_MASK, 8'h01);
    `CHK("irq unmask", 1'b1, o_irq)
    wr(`PEF_OFS_FLAGS, 8'hFF);
    `CHK("irq clr", 1'b0, o_irq)
    $display("test irq done");
    complete_run();
  end
endmodule // peripheral_event_flag_register_tb
